// ==== logic/motion_output_ctrl.sv ====
// Motor enable sequencing, rated current limit and motion output usage.
// Assumes synchronous inputs, one clock and a plain register port.
//
// Notes on behaviour
// - Rated current readable, writable, 0 to 10 A.
// - Rated current caps the running current.
// - Rated current is handed to motor probing.
// - Disable engages brake, current drops after delay.
// - Forbidden enable is refused, reply is ampersand.
// - Enable releases brake, current returns after delay.
// - Re-enable resumes the previous operating mode.
// - Standard I/O: codes 1, 2 set idle level.
// - Code 3 frees the output for others.
// - Codes 4 to 8 give tach pulses.
// - One function owns each output at once.
// - Variable I/O: point 1-4, must be output except for code 3.
// - Variable I/O: codes 1, 2 track position error.
// - Motion codes override; alarm/brake force code 3.
// - Energized means logic low, released means high.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module motion_output_ctrl #(
  parameter int CYC_PER_MS = motion_pkg::CYC_PER_MS
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire motion_pkg::bus_req_type     bus_req,
  output logic [31:0]                      rdata,
  input  wire motion_pkg::io_in_type       io_in,
  input  wire logic                        enable_allowed,
  input  wire logic                        variable_io,
  output logic [motion_pkg::CUR_W-1:0]     motor_current,
  output logic [motion_pkg::CUR_W-1:0]     probe_current,
  output logic                             brake_active,
  output logic                             drive_active,
  output logic                             nv_write,
  output logic [motion_pkg::N_POINTS-1:0]  point_level,
  output logic [motion_pkg::N_POINTS-1:0]  point_owned
);

  typedef struct packed {
    motion_pkg::drive_state_type         state;
    logic [motion_pkg::CUR_W-1:0]        rated;
    logic [motion_pkg::CUR_W-1:0]        run_req;
    logic [motion_pkg::CUR_W-1:0]        current;
    logic [3:0]                          usage;
    logic [2:0]                          point;
    logic [7:0]                          owner;
    logic [motion_pkg::DLY_W-1:0]        engage_dly;
    logic [motion_pkg::DLY_W-1:0]        release_dly;
    logic                                refused;
    logic                                tmr_start;
    logic [3:0]                          tach_cnt;
    logic                                tach_pulse;
    logic                                nv_write;
    logic [3:0]                          level;
    logic [3:0]                          owned;
    logic [31:0]                         rdata;
  } ctrl_state_type;

  ctrl_state_type st_ff;
  ctrl_state_type nxt_st;
  logic           tmr_done;
  logic [3:0]     tach_last;
  logic [3:0]     level_c;
  logic [3:0]     owned_c;

  delay_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .clk      (clk),
    .rstn     (rstn),
    .start    (st_ff.tmr_start),
    .delay_ms (st_ff.state == motion_pkg::ST_ENGAGE ?
               st_ff.engage_dly : st_ff.release_dly),
    .done     (tmr_done)
  );

  // Tach divide ratio: sixteenth down to every tick of a 1600 per rev source.
  always_comb begin
    unique case (st_ff.usage)
      4'h4:    tach_last = 4'hF;
      4'h5:    tach_last = 4'h7;
      4'h6:    tach_last = 4'h3;
      4'h7:    tach_last = 4'h1;
      default: tach_last = 4'h0;
    endcase
  end

  // Per point, the owning function decides the level; low is energized.
  genvar gp;
  generate
    for (gp = 0; gp < motion_pkg::N_POINTS; gp++) begin : g_point
      logic [1:0] own;
      logic       still;
      assign own   = st_ff.owner[2*gp +: 2];
      assign still = variable_io ? io_in.pos_err_small : !io_in.moving;
      always_comb begin
        owned_c[gp] = (own != motion_pkg::OWN_GP);
        level_c[gp] = io_in.gp_level[gp];
        unique case (own)
          motion_pkg::OWN_ALARM: level_c[gp] = !io_in.alarm_active;
          motion_pkg::OWN_BRAKE: level_c[gp] =
            !(st_ff.state inside {motion_pkg::ST_OFF,
                                  motion_pkg::ST_ENGAGE});
          motion_pkg::OWN_MOTION: begin
            if (st_ff.usage >= motion_pkg::USE_TACH_100) begin
              level_c[gp] = !st_ff.tach_pulse;
            end else if (variable_io) begin
              level_c[gp] = (st_ff.usage == motion_pkg::USE_STILL_LOW)
                            ? still : !still;
            end else begin
              level_c[gp] = (st_ff.usage == motion_pkg::USE_STILL_LOW)
                            ? !still : still;
            end
          end
          default: level_c[gp] = io_in.gp_level[gp];
        endcase
      end
    end
  endgenerate

  always_comb begin
    logic [3:0]  u;
    logic [2:0]  p;
    logic [1:0]  pi;
    logic [1:0]  f;
    logic [9:0]  v;
    u  = 4'h0;
    p  = 3'h0;
    pi = 2'h0;
    f  = 2'h0;
    v  = 10'h000;
    nxt_st = st_ff;
    nxt_st.tmr_start = 1'b0;
    nxt_st.nv_write = 1'b0;
    nxt_st.rdata = 32'h0000_0000;
    nxt_st.level = level_c;
    nxt_st.owned = owned_c;

    // Tach pulses count ticks only while the output is a tach output.
    nxt_st.tach_pulse = 1'b0;
    if (st_ff.usage >= motion_pkg::USE_TACH_100 && io_in.tach_tick) begin
      if (st_ff.tach_cnt >= tach_last) begin
        nxt_st.tach_cnt = 4'h0;
        nxt_st.tach_pulse = 1'b1;
      end else begin
        nxt_st.tach_cnt = st_ff.tach_cnt + 4'h1;
      end
    end

    // Brake sequencing.
    unique case (st_ff.state)
      motion_pkg::ST_ENGAGE:
        if (tmr_done && !st_ff.tmr_start) begin
          nxt_st.state = motion_pkg::ST_OFF;
        end
      motion_pkg::ST_RELEASE:
        if (tmr_done && !st_ff.tmr_start) begin
          nxt_st.state = motion_pkg::ST_ON;
        end
      motion_pkg::ST_OFF:
        nxt_st.state = motion_pkg::ST_OFF;
      motion_pkg::ST_ON:
        nxt_st.state = motion_pkg::ST_ON;
    endcase

    if (bus_req.wr) begin
      unique case (bus_req.addr)
        motion_pkg::OFS_RATED_CUR: begin
          v = bus_req.wdata[9:0];
          if (bus_req.wdata[31:10] == '0 && v <= motion_pkg::RATED_MAX) begin
            nxt_st.rated = v;
            nxt_st.nv_write = 1'b1;
          end
        end
        motion_pkg::OFS_RUN_CUR: nxt_st.run_req = bus_req.wdata[9:0];
        motion_pkg::OFS_COMMAND: begin
          if (bus_req.wdata[motion_pkg::CMD_DISABLE_BIT]) begin
            if (st_ff.state inside {motion_pkg::ST_ON,
                                    motion_pkg::ST_RELEASE}) begin
              nxt_st.state = motion_pkg::ST_ENGAGE;
              nxt_st.tmr_start = 1'b1;
            end
          end else if (bus_req.wdata[motion_pkg::CMD_ENABLE_BIT]) begin
            if (!enable_allowed) begin
              nxt_st.refused = 1'b1;
            end else if (st_ff.state inside {motion_pkg::ST_OFF,
                                             motion_pkg::ST_ENGAGE}) begin
              nxt_st.state = motion_pkg::ST_RELEASE;
              nxt_st.tmr_start = 1'b1;
            end
          end
        end
        motion_pkg::OFS_USAGE: begin
          u = bus_req.wdata[motion_pkg::USAGE_LSB +: 4];
          p = variable_io ? bus_req.wdata[motion_pkg::POINT_LSB +: 3]
                          : motion_pkg::POINT_RST;
          pi = p[1:0] - 2'h1;
          if (u >= motion_pkg::USE_STILL_LOW &&
              u <= motion_pkg::USE_TACH_1600 &&
              p >= 3'h1 && p <= 3'h4 &&
              (u == motion_pkg::USE_FREE || !variable_io ||
               io_in.point_is_output[pi])) begin
            for (int i = 0; i < motion_pkg::N_POINTS; i++) begin
              if (st_ff.owner[2*i +: 2] == motion_pkg::OWN_MOTION) begin
                nxt_st.owner[2*i +: 2] = motion_pkg::OWN_GP;
              end
            end
            if (u != motion_pkg::USE_FREE) begin
              nxt_st.owner[2*pi +: 2] = motion_pkg::OWN_MOTION;
            end
            nxt_st.usage = u;
            nxt_st.point = p;
            nxt_st.tach_cnt = 4'h0;
            nxt_st.nv_write = 1'b1;
          end
        end
        motion_pkg::OFS_ENGAGE_DLY:
          nxt_st.engage_dly = bus_req.wdata[15:0];
        motion_pkg::OFS_RELEASE_DLY:
          nxt_st.release_dly = bus_req.wdata[15:0];
        motion_pkg::OFS_OWNER: begin
          f = bus_req.wdata[1:0];
          p = variable_io ? bus_req.wdata[motion_pkg::POINT_LSB +: 3]
                          : motion_pkg::POINT_RST;
          pi = p[1:0] - 2'h1;
          if (f != motion_pkg::OWN_MOTION && p >= 3'h1 && p <= 3'h4) begin
            if (st_ff.owner[2*pi +: 2] == motion_pkg::OWN_MOTION &&
                f != motion_pkg::OWN_GP) begin
              nxt_st.usage = motion_pkg::USE_FREE;
              nxt_st.nv_write = 1'b1;
            end
            if (f != motion_pkg::OWN_GP ||
                st_ff.owner[2*pi +: 2] != motion_pkg::OWN_MOTION) begin
              nxt_st.owner[2*pi +: 2] = f;
            end
          end
        end
        default: nxt_st.refused = nxt_st.refused;
      endcase
    end

    if (bus_req.rd) begin
      unique case (bus_req.addr)
        motion_pkg::OFS_RATED_CUR: nxt_st.rdata = {22'h0, st_ff.rated};
        motion_pkg::OFS_RUN_CUR:   nxt_st.rdata = {22'h0, st_ff.run_req};
        motion_pkg::OFS_USAGE:
          nxt_st.rdata = {25'h0, st_ff.point, st_ff.usage};
        motion_pkg::OFS_ENGAGE_DLY:
          nxt_st.rdata = {16'h0, st_ff.engage_dly};
        motion_pkg::OFS_RELEASE_DLY:
          nxt_st.rdata = {16'h0, st_ff.release_dly};
        motion_pkg::OFS_OWNER:     nxt_st.rdata = {24'h0, st_ff.owner};
        motion_pkg::OFS_STATUS:
          nxt_st.rdata = {24'h0, st_ff.state, 1'b0, st_ff.refused,
                          st_ff.state inside {motion_pkg::ST_OFF,
                                              motion_pkg::ST_ENGAGE},
                          st_ff.state == motion_pkg::ST_ON};
        motion_pkg::OFS_REPLY: begin
          nxt_st.rdata = st_ff.refused ?
                         {24'h0, motion_pkg::REPLY_REFUSED} : 32'h0;
          if (!(bus_req.wr && bus_req.addr == motion_pkg::OFS_COMMAND)) begin
            nxt_st.refused = 1'b0;
          end
        end
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    // Running current is capped by the rated value and zero while off.
    if (nxt_st.state inside {motion_pkg::ST_ON, motion_pkg::ST_ENGAGE}) begin
      nxt_st.current = (nxt_st.run_req > nxt_st.rated) ?
                       nxt_st.rated : nxt_st.run_req;
    end else begin
      nxt_st.current = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff             <= '0;
      st_ff.state       <= motion_pkg::ST_OFF;
      st_ff.rated       <= motion_pkg::RATED_RST;
      st_ff.run_req     <= motion_pkg::RUN_RST;
      st_ff.usage       <= motion_pkg::USAGE_RST;
      st_ff.point       <= motion_pkg::POINT_RST;
      st_ff.engage_dly  <= motion_pkg::ENGAGE_RST;
      st_ff.release_dly <= motion_pkg::RELEASE_RST;
      st_ff.level       <= 4'hF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata         = st_ff.rdata;
  assign motor_current = st_ff.current;
  assign probe_current = st_ff.rated;
  assign brake_active  = st_ff.state inside {motion_pkg::ST_OFF,
                                             motion_pkg::ST_ENGAGE} ?
                         1'b1 : 1'b0;
  assign drive_active  = st_ff.state == motion_pkg::ST_ON;
  assign nv_write      = st_ff.nv_write;
  assign point_level   = st_ff.level;
  assign point_owned   = st_ff.owned;

endmodule

// ==== shared/motion_pkg.sv ====
// Constants, register map, field layouts and carrier types of the
// motor enable and motion output block.
// Assumes a single 25 MHz clock and a plain register port.
package motion_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_RATED_CUR  = 8'h00;
  localparam logic [7:0] OFS_RUN_CUR    = 8'h04;
  localparam logic [7:0] OFS_COMMAND    = 8'h08;
  localparam logic [7:0] OFS_USAGE      = 8'h0C;
  localparam logic [7:0] OFS_ENGAGE_DLY = 8'h10;
  localparam logic [7:0] OFS_RELEASE_DLY = 8'h14;
  localparam logic [7:0] OFS_OWNER      = 8'h18;
  localparam logic [7:0] OFS_STATUS     = 8'h1C;
  localparam logic [7:0] OFS_REPLY      = 8'h20;

  // Current in hundredths of an amp.
  localparam int          CUR_W         = 10;
  localparam logic [9:0]  RATED_MAX     = 10'h3E8;
  localparam logic [9:0]  RATED_RST     = 10'h064;
  localparam logic [9:0]  RUN_RST       = 10'h064;

  // Command register bits.
  localparam int          CMD_DISABLE_BIT = 0;
  localparam int          CMD_ENABLE_BIT  = 1;

  // Usage register fields and codes.
  localparam int          USAGE_LSB     = 0;
  localparam int          POINT_LSB     = 4;
  localparam logic [3:0]  USE_STILL_LOW = 4'h1;
  localparam logic [3:0]  USE_STILL_HIGH = 4'h2;
  localparam logic [3:0]  USE_FREE      = 4'h3;
  localparam logic [3:0]  USE_TACH_100  = 4'h4;
  localparam logic [3:0]  USE_TACH_1600 = 4'h8;
  localparam logic [3:0]  USAGE_RST     = 4'h3;
  localparam logic [2:0]  POINT_RST     = 3'h1;
  localparam int          N_POINTS      = 4;

  // Output owner codes.
  localparam logic [1:0]  OWN_GP        = 2'h0;
  localparam logic [1:0]  OWN_ALARM     = 2'h1;
  localparam logic [1:0]  OWN_BRAKE     = 2'h2;
  localparam logic [1:0]  OWN_MOTION    = 2'h3;

  // Status register bits.
  localparam int          STS_ENABLED   = 0;
  localparam int          STS_BRAKE     = 1;
  localparam int          STS_REFUSED   = 2;
  localparam int          STS_STATE_LSB = 4;

  // Reply character for a refused enable.
  localparam logic [7:0]  REPLY_REFUSED = 8'h26;

  // Brake delays in milliseconds.
  localparam int          DLY_W         = 16;
  localparam logic [15:0] ENGAGE_RST    = 16'h0000;
  localparam logic [15:0] RELEASE_RST   = 16'h0000;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          MS_NS         = 1000000;
  localparam int          CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int          CYC_W         = 24;

  typedef enum logic [3:0] {
    ST_OFF     = 4'h1,
    ST_RELEASE = 4'h2,
    ST_ON      = 4'h4,
    ST_ENGAGE  = 4'h8
  } drive_state_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    logic        moving;
    logic        pos_err_small;
    logic        tach_tick;
    logic        alarm_active;
    logic [3:0]  gp_level;
    logic [3:0]  point_is_output;
  } io_in_type;

  typedef struct packed {
    logic              busy;
    logic [DLY_W-1:0]  ms_left;
    logic [CYC_W-1:0]  cyc;
    logic              done;
  } timer_state_type;

endpackage

// ==== logic/delay_timer.sv ====
// Millisecond delay timer used for brake engage and release waits.
// Assumes start is a one-cycle pulse; a new start restarts the wait.
`timescale 1ns/100ps
module delay_timer #(
  parameter int CYC_PER_MS = motion_pkg::CYC_PER_MS
) (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         start,
  input  wire logic [motion_pkg::DLY_W-1:0] delay_ms,
  output logic                              done
);

  motion_pkg::timer_state_type st_ff;
  motion_pkg::timer_state_type nxt_st;

  localparam logic [motion_pkg::CYC_W-1:0] CYC_LAST =
    motion_pkg::CYC_W'(CYC_PER_MS - 1);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.ms_left = delay_ms;
      nxt_st.cyc = '0;
    end else if (st_ff.busy) begin
      if (st_ff.ms_left == '0) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end else if (st_ff.cyc == CYC_LAST) begin
        nxt_st.cyc = '0;
        nxt_st.ms_left = st_ff.ms_left - 1'b1;
      end else begin
        nxt_st.cyc = st_ff.cyc + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign done = st_ff.done;

endmodule

// ==== tb/motion_checker.sv ====
// Port assertions and covers for the motor enable and motion output block.
// Bound to every instance of the block; sees only its ports.
`timescale 1ns/100ps
module motion_checker #(
  parameter int CYC_PER_MS = 4
) (
  input wire logic                       clk,
  input wire logic                       rstn,
  input wire motion_pkg::bus_req_type    bus_req,
  input wire logic [31:0]                rdata,
  input wire motion_pkg::io_in_type      io_in,
  input wire logic                       enable_allowed,
  input wire logic                       variable_io,
  input wire logic [9:0]                 motor_current,
  input wire logic [9:0]                 probe_current,
  input wire logic                       brake_active,
  input wire logic                       drive_active,
  input wire logic                       nv_write,
  input wire logic [3:0]                 point_level,
  input wire logic [3:0]                 point_owned
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic enable_req;
  assign enable_req = bus_req.wr && bus_req.addr == motion_pkg::OFS_COMMAND
    && bus_req.wdata[1] && !bus_req.wdata[0];
  chk_probe_range: assert property (
    probe_current <= motion_pkg::RATED_MAX)
    else $error("probe current above ceiling");
  chk_run_ceiling: assert property (
    motor_current <= probe_current)
    else $error("motor current above rated value");
  chk_brake_drive: assert property (
    !(brake_active && drive_active))
    else $error("brake and drive active together");
  chk_release_zero: assert property (
    !brake_active && !drive_active |-> motor_current == 10'h000)
    else $error("current before release delay ended");
  chk_rise_release: assert property (
    $rose(drive_active) |-> !$past(brake_active))
    else $error("drive enabled without brake release");
  chk_fall_engage: assert property (
    $fell(drive_active) |-> brake_active)
    else $error("disable without brake engage");
  chk_refused_hold: assert property (
    enable_req && !enable_allowed && brake_active && !drive_active
    |=> brake_active [*3])
    else $error("forbidden enable released brake");
  chk_nv_cause: assert property (
    nv_write |-> $past(bus_req.wr) &&
    ($past(bus_req.addr) == motion_pkg::OFS_RATED_CUR ||
     $past(bus_req.addr) == motion_pkg::OFS_USAGE ||
     $past(bus_req.addr) == motion_pkg::OFS_OWNER))
    else $error("store pulse without a parameter write");
  chk_rdata_idle: assert property (
    !$past(bus_req.rd) |-> rdata == 32'h0)
    else $error("read data outside read cycle");
  cov_enable: cover property ($rose(drive_active));
  cov_refused: cover property (enable_req && !enable_allowed);
  cov_store: cover property (nv_write);
endmodule
bind motion_output_ctrl motion_checker #(.CYC_PER_MS(CYC_PER_MS)) i_chk (
  .clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
  .io_in(io_in), .enable_allowed(enable_allowed),
  .variable_io(variable_io), .motor_current(motor_current),
  .probe_current(probe_current), .brake_active(brake_active),
  .drive_active(drive_active), .nv_write(nv_write),
  .point_level(point_level), .point_owned(point_owned));

// ==== tb/host_model.sv ====
// Host controller model driving the register port of the block.
// Assumes each task is entered just after a rising clock edge.
`timescale 1ns/100ps
module host_model (
  input  wire logic               clk,
  output motion_pkg::bus_req_type bus_req
);
  initial bus_req = '0;
  // One strobe cycle, then an idle cycle with inverted address and data.
  task automatic put(input logic [7:0] a, input logic [31:0] d,
                     input logic w);
    bus_req <= '{a, d, w, !w};
    @(posedge clk);
    bus_req <= '{~a, ~d, 1'b0, 1'b0};
    @(posedge clk);
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench of the motor enable and motion output block.
// Assumes a 25 MHz clock and a shortened millisecond count of 4 cycles.
`timescale 1ns/100ps
module tb;
  logic                    clk;
  logic                    rstn;
  motion_pkg::bus_req_type bus_req;
  logic [31:0]             rdata;
  motion_pkg::io_in_type   io_in;
  logic                    enable_allowed;
  logic                    variable_io;
  logic [9:0]              motor_current;
  logic [9:0]              probe_current;
  logic                    brake_active;
  logic                    drive_active;
  logic                    nv_write;
  logic [3:0]              point_level;
  logic [3:0]              point_owned;
  logic [31:0]             exp_q[$];
  logic                    rd_q = 1'b0;
  logic [9:0]              rated;
  logic [3:0]              gp;
  int                      errors = 0;
  int                      num_checks = 0;
  int                      n;
  int                      stores = 0;

  host_model i_host (.clk(clk), .bus_req(bus_req));
  motion_output_ctrl #(.CYC_PER_MS(4)) i_dut (
    .clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .io_in(io_in), .enable_allowed(enable_allowed),
    .variable_io(variable_io), .motor_current(motor_current),
    .probe_current(probe_current), .brake_active(brake_active),
    .drive_active(drive_active), .nv_write(nv_write),
    .point_level(point_level), .point_owned(point_owned));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.put(a, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_host.put(a, 32'h0, 1'b0);
  endtask

  // Waits for drive_active (which 0) or motor_current (which 1) to be v.
  task automatic wait_sig(input int which, input logic [9:0] v,
                          output int cnt);
    cnt = 0;
    while ((which == 0 ? {9'h0, drive_active} : motor_current) !== v) begin
      @(negedge clk);
      cnt++;
      if (cnt > 200) begin
        check("wait bound", 32'h0, 32'h1);
        results();
      end
    end
    @(posedge clk);
  endtask

  always @(negedge clk) begin
    if (rd_q) begin
      if (exp_q.size() == 0) check("read note", 32'h1, 32'h0);
      else check("rdata", exp_q.pop_front(), rdata);
    end
    if (nv_write) stores++;
    rd_q = bus_req.rd;
  end

  initial begin
    rstn = 1'b0;
    enable_allowed = 1'b0;
    variable_io = 1'b0;
    io_in = '0;
    void'($urandom(86));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(motion_pkg::OFS_RATED_CUR, 32'h64);
    rd(motion_pkg::OFS_USAGE, 32'h13);
    rd(motion_pkg::OFS_STATUS, 32'h12);
    rd(8'h24, 32'h0);
    check("probe_current", 32'h64, probe_current);
    rated = 10'($urandom_range(1000, 100));
    wr(motion_pkg::OFS_RATED_CUR, {22'h0, rated});
    wr(motion_pkg::OFS_RATED_CUR, 32'h3E9);
    rd(motion_pkg::OFS_RATED_CUR, {22'h0, rated});
    check("probe_current", rated, probe_current);
    wr(motion_pkg::OFS_RUN_CUR, 32'h3FF);
    wr(motion_pkg::OFS_COMMAND, 32'h2);
    rd(motion_pkg::OFS_STATUS, 32'h16);
    rd(motion_pkg::OFS_REPLY, 32'h26);
    rd(motion_pkg::OFS_REPLY, 32'h0);
    enable_allowed <= 1'b1;
    wr(motion_pkg::OFS_RELEASE_DLY, 32'h2);
    wr(motion_pkg::OFS_COMMAND, 32'h2);
    check("brake_active", 32'h0, brake_active);
    wait_sig(0, 10'h1, n);
    check("release wait", 32'h1, 32'(n >= 7));
    check("motor_current", rated, motor_current);
    rd(motion_pkg::OFS_STATUS, 32'h41);
    wr(motion_pkg::OFS_ENGAGE_DLY, 32'h1);
    wr(motion_pkg::OFS_COMMAND, 32'h3);
    check("brake_active", 32'h1, brake_active);
    check("motor_current", rated, motor_current);
    wait_sig(1, 10'h0, n);
    check("engage wait", 32'h1, 32'(n >= 3));
    for (int c = 1; c <= 8; c++) begin
      wr(motion_pkg::OFS_USAGE, 32'h10 | c);
      rd(motion_pkg::OFS_USAGE, 32'h10 | c);
    end
    wr(motion_pkg::OFS_USAGE, 32'h19);
    rd(motion_pkg::OFS_USAGE, 32'h18);
    for (int c = 4; c <= 8; c++) begin
      wr(motion_pkg::OFS_USAGE, 32'h10 | c);
      n = 0;
      for (int t = 0; t < 40; t++) begin
        io_in.tach_tick <= (t < 32) && !t[0];
        @(negedge clk);
        if (point_level[0] === 1'b0) n++;
        @(posedge clk);
      end
      check("tach pulses", 1 << (c - 4), n);
    end
    io_in.point_is_output <= 4'hF;
    io_in.pos_err_small <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      variable_io <= k[2];
      io_in.moving <= k[0];
      wr(motion_pkg::OFS_USAGE, (k[2] ? 32'h21 : 32'h11) + k[1]);
      repeat (3) @(posedge clk);
      check("point_level", k[2] ? !k[1] : k[1] ^ k[0],
            point_level[k[2]]);
      check("point_owned", 32'h1, point_owned[k[2]]);
    end
    gp = 4'($urandom);
    io_in.gp_level <= gp;
    wr(motion_pkg::OFS_USAGE, 32'h23);
    repeat (3) @(posedge clk);
    check("point_owned", 32'h0, point_owned[1]);
    check("point_level", gp[1], point_level[1]);
    wr(motion_pkg::OFS_USAGE, 32'h22);
    io_in.alarm_active <= 1'b1;
    wr(motion_pkg::OFS_OWNER, 32'h21);
    wr(motion_pkg::OFS_OWNER, 32'h32);
    rd(motion_pkg::OFS_USAGE, 32'h23);
    rd(motion_pkg::OFS_OWNER, 32'h24);
    check("point_level", 32'h0, point_level[1]);
    check("point_level", 32'h0, point_level[2]);
    check("point_owned", 32'h6, point_owned);
    repeat (3) @(posedge clk);
    check("store pulses", 32'h19, stores);
    results();
  end
endmodule
